//--- logic/pss_sequencer.sv
// pss_sequencer: power sequencing, fault supervision, hiccup, pwm gate, reset output
// assumes analog comparators arrive as asynchronous pins; one AHB-Lite master, word access
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
module pss_sequencer
    import pss_pkg::*;
#(
    parameter int POR_CYC = POR_ON_DELAY_CYC,
    parameter int HIC_CYC = HICCUP_REC_CYC,
    parameter int WDP_CYC = WD_PULSE_CYC,
    parameter int WDF_CYC = WD_FAST_STEP_CYC,
    parameter int WDS_CYC = WD_SLOW_STEP_CYC
) (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire pss_pin_s pins_in,
    output logic prereg_on_out,
    output logic ldo_on_out,
    output logic switch_gate_out,
    output logic power_good_reset_n_out,
    output logic default_freq_out,
    output logic hiccup_out
);
    localparam logic [TW-1:0] POR_T = TW'(POR_CYC);
    localparam logic [TW-1:0] HIC_T = TW'(HIC_CYC);
    localparam logic [TW-1:0] WDP_T = TW'(WDP_CYC);
    localparam logic [TW-1:0] WDF_T = TW'(WDF_CYC);
    localparam logic [TW-1:0] WDS_T = TW'(WDS_CYC);
    localparam logic [11:0] LDO_OFF_T = 12'(LDO_OFF_DELAY_CYC);
    localparam logic [2:0] DG_RST = 3'b010;

    pss_pin_s s1, s;
    logic [2:0] dg_raw, dg_filt;
    logic en_f, main_uv_f;
    pss_state_e state, next_state;
    logic [11:0] dly_cnt;
    logic [2:0] latch, lat_set;
    logic mpor;
    pss_ctrl_s ctrl;
    pss_pwm_s pwm;
    logic [7:0] pwm_cnt, eff_period;
    logic cyc_end, sw_en, oc_seen, oc_cycle;
    logic [5:0] oc_cnt, oc_limit;
    logic [TW-1:0] hic_cnt, por_cnt, wd_tick, wd_pulse, step_t;
    logic por_hold, wd_prev, kick, wd_active, wd_fire;
    logic [4:0] wd_steps, wd_limit;
    logic ap_wr;
    logic [7:0] ap_addr;
    logic [31:0] rd_val;

    // two-stage synchroniser for every analog and pin input
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            s1 <= '0;
            s <= '0;
        end
        else
        begin
            s1 <= pins_in;
            s <= s1;
        end
    end

    assign dg_raw = {s.freq_set_sync_pin_open | s.freq_set_sync_pin_short, s.main_ldo_undervoltage,
                     s.ignition_enable};
    assign en_f = dg_filt[0];
    assign main_uv_f = dg_filt[1];

    // filtered level follows the raw one only after it has differed for the whole window
    for (genvar g = 0; g < 3; g++)
    begin : g_dg
        localparam logic [11:0] CYC = (g == 2) ? 12'(FSET_DETECT_CYC) : 12'(DEGLITCH_CYC);
        logic [11:0] cnt;
        always_ff @(posedge ref_clk_in or negedge arst_n_in)
        begin
            if (!arst_n_in)
            begin
                cnt <= '0;
                dg_filt[g] <= DG_RST[g];
            end
            else if (dg_raw[g] == dg_filt[g])
                cnt <= '0;
            else if (cnt == CYC - 12'd1)
            begin
                cnt <= '0;
                dg_filt[g] <= dg_raw[g];
            end
            else
                cnt <= cnt + 12'd1;
        end
    end

    // latched faults: set wins over the enable-low clear
    assign lat_set = {s.prereg_overvoltage, s.switch_node_short, s.catch_diode_missing};
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            latch <= '0;
        else
            latch <= (en_f ? latch : 3'b000) | lat_set;
    end

    assign mpor = s.ref_one_undervoltage | s.ref_two_undervoltage | s.input_undervoltage
                | s.thermal_shutdown | s.charge_pump_undervoltage | s.charge_pump_overvoltage
                | (|latch);

    always_comb
    begin
        next_state = state;
        if (mpor)
            next_state = ST_RESET;
        else
            case (state)
                ST_RESET: next_state = ST_OFF;
                ST_OFF: if (en_f) next_state = ST_STARTUP;
                ST_STARTUP:
                    if (!en_f)
                        next_state = ST_OFF;
                    else if (!s.prereg_undervoltage)
                        next_state = ST_LDO_RAMP;
                ST_LDO_RAMP:
                    if (!en_f)
                        next_state = ST_DELAY;
                    else if (!s.main_ldo_undervoltage)
                        next_state = ST_RUN;
                ST_RUN: if (!en_f) next_state = ST_DELAY;
                ST_DELAY:
                    if (en_f)
                        next_state = ST_RUN;
                    else if (dly_cnt == LDO_OFF_T - 12'd1)
                        next_state = ST_SHUTDOWN;
                ST_SHUTDOWN: if (s.main_ldo_undervoltage) next_state = ST_OFF;
                default: next_state = ST_RESET;
            endcase
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state <= ST_OFF;
            dly_cnt <= '0;
            prereg_on_out <= 1'b0;
            ldo_on_out <= 1'b0;
        end
        else
        begin
            state <= next_state;
            dly_cnt <= (next_state == ST_DELAY) ? dly_cnt + 12'd1 : 12'd0;
            prereg_on_out <= next_state inside {ST_STARTUP, ST_LDO_RAMP, ST_RUN, ST_DELAY, ST_SHUTDOWN};
            ldo_on_out <= next_state inside {ST_LDO_RAMP, ST_RUN, ST_DELAY};
        end
    end

    // pwm cycle, pulse-by-pulse limit and hiccup counting
    assign eff_period = dg_filt[2] ? 8'(DEFAULT_PERIOD_CYC) : pwm.period;
    assign cyc_end = pwm_cnt >= eff_period - 8'd1;
    assign sw_en = prereg_on_out & !hiccup_out;
    assign oc_cycle = oc_seen | (switch_gate_out & s.overcurrent);
    assign oc_limit = s.prereg_below_2v4 ? 6'(HIC_COUNT_LOW) : 6'(HIC_COUNT_HIGH);

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            pwm_cnt <= '0;
            oc_seen <= 1'b0;
            switch_gate_out <= 1'b0;
            default_freq_out <= 1'b0;
        end
        else
        begin
            pwm_cnt <= cyc_end ? 8'd0 : pwm_cnt + 8'd1;
            oc_seen <= cyc_end ? 1'b0 : oc_cycle;
            switch_gate_out <= sw_en & (pwm_cnt < pwm.duty) & !oc_cycle;
            default_freq_out <= dg_filt[2];
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            oc_cnt <= '0;
            hic_cnt <= '0;
            hiccup_out <= 1'b0;
        end
        else if (hiccup_out)
        begin
            oc_cnt <= '0;
            hic_cnt <= hic_cnt + 1'b1;
            if (hic_cnt == HIC_T - 1'b1)
            begin
                hic_cnt <= '0;
                hiccup_out <= 1'b0;
            end
        end
        else if (cyc_end)
        begin
            if (!(sw_en & oc_cycle & s.error_amp_max))
                oc_cnt <= '0;
            else if (oc_cnt + 6'd1 >= oc_limit)
            begin
                oc_cnt <= '0;
                hiccup_out <= 1'b1;
            end
            else
                oc_cnt <= oc_cnt + 6'd1;
        end
    end

    // reset output: turn-on delay, prompt fall, watchdog pulse
    assign por_hold = main_uv_f | !en_f | mpor;
    assign kick = s.wd_service & !wd_prev;
    assign wd_active = ctrl.wd_en & (state == ST_RUN) & power_good_reset_n_out;
    assign step_t = ctrl.wd_slow ? WDS_T : WDF_T;
    assign wd_limit = (ctrl.wd_step == 5'd0) ? 5'd1 :
                      (ctrl.wd_step > 5'(WD_STEPS_MAX)) ? 5'(WD_STEPS_MAX) : ctrl.wd_step;
    assign wd_fire = wd_active & !kick & (wd_tick == step_t - 1'b1) & (wd_steps == wd_limit - 5'd1);

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            por_cnt <= '0;
            power_good_reset_n_out <= 1'b0;
        end
        else
        begin
            por_cnt <= por_hold ? '0 : (por_cnt == POR_T) ? por_cnt : por_cnt + 1'b1;
            power_good_reset_n_out <= !por_hold & (por_cnt == POR_T) & !wd_fire & (wd_pulse < TW'(2));
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            wd_prev <= 1'b0;
            wd_tick <= '0;
            wd_steps <= '0;
            wd_pulse <= '0;
        end
        else
        begin
            wd_prev <= s.wd_service;
            if (!wd_active | kick | wd_fire)
            begin
                wd_tick <= '0;
                wd_steps <= '0;
            end
            else if (wd_tick == step_t - 1'b1)
            begin
                wd_tick <= '0;
                wd_steps <= wd_steps + 5'd1;
            end
            else
                wd_tick <= wd_tick + 1'b1;
            if (wd_fire)
                wd_pulse <= WDP_T;
            else if (wd_pulse != '0)
                wd_pulse <= wd_pulse - 1'b1;
        end
    end

    // AHB-Lite slave, zero wait states, always OKAY
    always_comb
    begin
        case (haddr_in[7:0])
            ADDR_CTRL: rd_val = ctrl;
            ADDR_PWM: rd_val = pwm;
            ADDR_STATUS: rd_val = pss_status_s'{rsv_hi: '0, ldo_on: ldo_on_out, prereg_on: prereg_on_out,
                reset_n: power_good_reset_n_out, default_freq: default_freq_out, hiccup: hiccup_out,
                rsv_mid: 1'b0, latched: latch, rsv_lo: 1'b0, state: state};
            default: rd_val = '0;
        endcase
        if (ap_wr && ap_addr == haddr_in[7:0] && ap_addr == ADDR_CTRL)
            rd_val = {19'h0, hwdata_in[12:8], 6'h0, hwdata_in[1:0]};
        if (ap_wr && ap_addr == haddr_in[7:0] && ap_addr == ADDR_PWM)
            rd_val = {16'h0, hwdata_in[15:0]};
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            ap_wr <= 1'b0;
            ap_addr <= '0;
            hrdata_out <= '0;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
            ctrl <= CTRL_RST;
            pwm <= PWM_RST;
        end
        else
        begin
            ap_wr <= hsel_in & hready_in & htrans_in[1] & hwrite_in & (hsize_in == 3'h2);
            ap_addr <= haddr_in[7:0];
            if (hsel_in & hready_in & htrans_in[1] & !hwrite_in)
                hrdata_out <= rd_val;
            if (ap_wr && ap_addr == ADDR_CTRL)
            begin
                ctrl.wd_step <= hwdata_in[12:8];
                ctrl.wd_slow <= hwdata_in[1];
                ctrl.wd_en <= hwdata_in[0];
            end
            if (ap_wr && ap_addr == ADDR_PWM)
                pwm[15:0] <= hwdata_in[15:0];
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);

    property p_mpor_off;
        mpor |=> !prereg_on_out && !ldo_on_out && state == ST_RESET;
    endproperty
    a_mpor_off: assert property (p_mpor_off) else $error("regulators on during master reset");
    property p_ldo_after_prereg;
        $rose(ldo_on_out) |-> $past(prereg_on_out) && !$past(s.prereg_undervoltage);
    endproperty
    a_ldo_after_prereg: assert property (p_ldo_after_prereg) else $error("LDOs before prereg");
    property p_ldo_hold;
        $fell(ldo_on_out) && state == ST_SHUTDOWN |-> $past(dly_cnt) == LDO_OFF_T - 12'd1;
    endproperty
    a_ldo_hold: assert property (p_ldo_hold) else $error("LDO shutdown delay wrong");
    property p_enable_low_reset;
        !en_f |-> ##1 !power_good_reset_n_out;
    endproperty
    a_enable_low_reset: assert property (p_enable_low_reset) else $error("reset not low after enable");
    property p_por_release;
        $rose(power_good_reset_n_out) |-> $past(por_cnt) == POR_T && !$past(main_uv_f);
    endproperty
    a_por_release: assert property (p_por_release) else $error("reset released early");
    property p_hic_low;
        cyc_end && sw_en && oc_cycle && s.error_amp_max && s.prereg_below_2v4
            && oc_cnt == 6'(HIC_COUNT_LOW - 1) |=> hiccup_out;
    endproperty
    a_hic_low: assert property (p_hic_low) else $error("no hiccup at low count");
    property p_hic_high;
        $rose(hiccup_out) && !$past(s.prereg_below_2v4) |-> $past(oc_cnt) == 6'(HIC_COUNT_HIGH - 1);
    endproperty
    a_hic_high: assert property (p_hic_high) else $error("hiccup at wrong high count");
    property p_pulse_limit;
        switch_gate_out && s.overcurrent && !cyc_end |=> !switch_gate_out;
    endproperty
    a_pulse_limit: assert property (p_pulse_limit) else $error("pulse not cut on overcurrent");
    property p_no_hic_wo_amp;
        !s.error_amp_max |=> !$rose(hiccup_out);
    endproperty
    a_no_hic_wo_amp: assert property (p_no_hic_wo_amp) else $error("hiccup without amplifier at maximum");
    property p_latch_hold;
        (|latch) && en_f |=> (|latch) && state == ST_RESET;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched fault lost");
    property p_default_freq;
        dg_filt[2] && cyc_end |=> pwm_cnt == 8'd0
            ##[1:54] (!dg_filt[2] || (cyc_end && pwm_cnt == 8'(DEFAULT_PERIOD_CYC - 1)));
    endproperty
    a_default_freq: assert property (p_default_freq) else $error("default period not used");
    property p_wd_pulse;
        wd_fire |=> !power_good_reset_n_out [*8];
    endproperty
    a_wd_pulse: assert property (p_wd_pulse) else $error("watchdog pulse too short");
    property p_hic_quiet;
        hiccup_out |=> !switch_gate_out;
    endproperty
    a_hic_quiet: assert property (p_hic_quiet) else $error("switching during hiccup");
endmodule : pss_sequencer

//--- pkg/pss_pkg.sv
// pss_pkg: timing counts, register layouts and carrier types of the power sequencer
// assumes a 50 MHz reference clock and a 32-bit AHB-Lite register bus
package pss_pkg;
    localparam int CLK_MHZ = 50;
    localparam int CLK_HZ = CLK_MHZ * 1_000_000;
    localparam int TW = 24;
    localparam int DEGLITCH_NS = 15_000;
    localparam int DEGLITCH_CYC = (DEGLITCH_NS * CLK_MHZ + 999) / 1000;
    localparam int FSET_DETECT_NS = 3_000;
    localparam int FSET_DETECT_CYC = (FSET_DETECT_NS * CLK_MHZ + 999) / 1000;
    localparam int LDO_OFF_DELAY_NS = 50_000;
    localparam int LDO_OFF_DELAY_CYC = (LDO_OFF_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int POR_ON_DELAY_NS = 22_500_000;
    localparam int POR_ON_DELAY_CYC = (POR_ON_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int WD_PULSE_NS = 2_000_000;
    localparam int WD_PULSE_CYC = (WD_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int HICCUP_REC_NS = 2_000_000;
    localparam int HICCUP_REC_CYC = (HICCUP_REC_NS * CLK_MHZ + 999) / 1000;
    localparam int WD_FAST_STEP_NS = 500_000;
    localparam int WD_FAST_STEP_CYC = (WD_FAST_STEP_NS * CLK_MHZ + 999) / 1000;
    localparam int WD_SLOW_STEP_NS = 4_000_000;
    localparam int WD_SLOW_STEP_CYC = (WD_SLOW_STEP_NS * CLK_MHZ + 999) / 1000;
    localparam int WD_STEPS_MAX = 25;
    localparam int DEFAULT_FREQ_HZ = 900_000;
    localparam int DEFAULT_PERIOD_CYC = CLK_HZ / DEFAULT_FREQ_HZ;
    localparam int HIC_COUNT_LOW = 15;
    localparam int HIC_COUNT_HIGH = 60;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PWM = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    typedef enum logic [2:0] {
        ST_OFF = 3'h0, ST_STARTUP = 3'h1, ST_LDO_RAMP = 3'h3, ST_RUN = 3'h2,
        ST_DELAY = 3'h6, ST_SHUTDOWN = 3'h7, ST_RESET = 3'h5
    } pss_state_e;
    typedef struct packed {
        logic ignition_enable;
        logic ref_one_undervoltage;
        logic ref_two_undervoltage;
        logic input_undervoltage;
        logic thermal_shutdown;
        logic charge_pump_undervoltage;
        logic charge_pump_overvoltage;
        logic catch_diode_missing;
        logic switch_node_short;
        logic prereg_overvoltage;
        logic prereg_undervoltage;
        logic main_ldo_undervoltage;
        logic prereg_below_2v4;
        logic error_amp_max;
        logic overcurrent;
        logic freq_set_sync_pin_open;
        logic freq_set_sync_pin_short;
        logic wd_service;
    } pss_pin_s;
    typedef struct packed {
        logic [18:0] rsv_hi;
        logic [4:0] wd_step;
        logic [5:0] rsv_lo;
        logic wd_slow;
        logic wd_en;
    } pss_ctrl_s;
    typedef struct packed {
        logic [15:0] rsv;
        logic [7:0] duty;
        logic [7:0] period;
    } pss_pwm_s;
    typedef struct packed {
        logic [18:0] rsv_hi;
        logic ldo_on;
        logic prereg_on;
        logic reset_n;
        logic default_freq;
        logic hiccup;
        logic rsv_mid;
        logic [2:0] latched;
        logic rsv_lo;
        logic [2:0] state;
    } pss_status_s;
    localparam pss_ctrl_s CTRL_RST = '{rsv_hi: '0, wd_step: 5'h01, rsv_lo: '0, wd_slow: 1'b0, wd_en: 1'b0};
    localparam pss_pwm_s PWM_RST = '{rsv: '0, duty: 8'h3e, period: 8'h7d};
endpackage : pss_pkg

//--- verification/pss_mcu_model.sv
// pss_mcu_model: microcontroller behind the reset output, services the watchdog
// assumes the bench gates servicing through svc_en_in; one clock shared with the sequencer
`timescale 1ns/1ns
module pss_mcu_model (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic power_good_reset_n_in,
    input wire logic svc_en_in,
    output logic wd_service_out
);
    logic [1:0] div;
    // toggles every four clocks while out of reset and svc_en_in is high, so a rising edge every eight
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            div <= 2'h0;
            wd_service_out <= 1'b0;
        end
        else if (power_good_reset_n_in && svc_en_in)
        begin
            div <= div + 2'h1;
            if (div == 2'h3)
                wd_service_out <= !wd_service_out;
        end
        else
            wd_service_out <= 1'b0;
    end
endmodule : pss_mcu_model

//--- verification/pss_sequencer_tb_top.sv
// pss_sequencer_tb_top: self-checking bench for the power sequencer
// assumes shortened timing parameters; pins driven directly, watchdog serviced by the model
`timescale 1ns/1ns
module pss_sequencer_tb_top;
    import pss_pkg::*;
    localparam int POR = 200;
    typedef struct {logic we; logic [7:0] a; logic [31:0] d; logic [31:0] e;} pss_row_s;
    logic ref_clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hready, hresp, prereg_on, ldo_on, gate, por_n, dflt, hic, wd_svc;
    logic svc_en = 1'b0;
    pss_pin_s pins, pins_drv;
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    int n, n6, cnt;
    int mr_bits[6] = '{16, 15, 14, 13, 12, 11};
    int lat_bits[3] = '{10, 9, 8};
    int fq_bits[2] = '{2, 1};
    pss_row_s rows[8] = '{
        '{1'b0, 8'h00, 32'h0, 32'h00000100}, '{1'b0, 8'h04, 32'h0, 32'h00003e7d},
        '{1'b0, 8'h08, 32'h0, 32'h0}, '{1'b1, 8'h0c, 32'hffffffff, 32'h0},
        '{1'b1, 8'h08, 32'hffffffff, 32'h0}, '{1'b1, 8'h00, 32'hffffffff, 32'h00001f03},
        '{1'b1, 8'h00, 32'h00000200, 32'h00000200}, '{1'b1, 8'h04, 32'h0000050a, 32'h0000050a}};

    always #10 ref_clk_in = !ref_clk_in;
    always_comb
    begin
        pins_drv = pins;
        pins_drv.wd_service = wd_svc;
    end

    pss_sequencer #(.POR_CYC(POR), .HIC_CYC(50), .WDP_CYC(20), .WDF_CYC(10), .WDS_CYC(40)) pss_sequencer_inst (
        .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .pins_in(pins_drv), .prereg_on_out(prereg_on), .ldo_on_out(ldo_on), .switch_gate_out(gate),
        .power_good_reset_n_out(por_n), .default_freq_out(dflt), .hiccup_out(hic));
    pss_mcu_model pss_mcu_model_inst (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
        .power_good_reset_n_in(por_n), .svc_en_in(svc_en), .wd_service_out(wd_svc));

    task automatic tally_and_finish;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    task automatic chk_bit(input logic got, input logic exp, input string m);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask : chk_bit

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask : chk_word

    function automatic logic pick(input int s);
        case (s)
            0: return prereg_on;
            1: return ldo_on;
            2: return por_n;
            3: return hic;
            4: return dflt;
            default: return gate;
        endcase
    endfunction : pick

    // counts clocks until the chosen output shows v, then checks the count lies in [lo, hi]
    task automatic wait_val(input int s, input logic v, input int lo, input int hi, output int k);
        k = 0;
        while (pick(s) !== v && k <= hi)
        begin
            @(posedge ref_clk_in);
            #1;
            k++;
        end
        chk_bit(k >= lo && k <= hi, 1'b1, $sformatf("output %0d settled after %0d clocks", s, k));
    endtask : wait_val

    task automatic hold_val(input int s, input logic v, input int len);
        int bad;
        bad = 0;
        repeat (len)
        begin
            @(posedge ref_clk_in);
            #1;
            bad += (pick(s) !== v);
        end
        chk_bit(bad == 0, 1'b1, $sformatf("output %0d left its level", s));
    endtask : hold_val

    task automatic count_gate(input int len, output int c);
        c = 0;
        repeat (len)
        begin
            @(posedge ref_clk_in);
            #1;
            c += (gate === 1'b1);
        end
    endtask : count_gate

    task automatic ahb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int t;
        t = 0;
        @(posedge ref_clk_in);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= we;
        hsize <= 3'h2;
        haddr <= {24'h0, a};
        do @(posedge ref_clk_in); while (hready !== 1'b1 && t++ < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk_in); while (hready !== 1'b1 && t++ < 50);
        r = hrdata;
    endtask : ahb

    always @(posedge ref_clk_in)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            fails++;
            tally_and_finish();
        end
    end

    initial
    begin
        pins = '0;
        pins.prereg_undervoltage = 1'b1;
        pins.main_ldo_undervoltage = 1'b1;
        repeat (8) @(posedge ref_clk_in);
        #1;
        chk_bit(por_n, 1'b0, "reset output during reset");
        chk_bit(hready, 1'b1, "bus ready during reset");
        @(posedge ref_clk_in);
        arst_n_in <= 1'b1;
        foreach (rows[i])
        begin
            if (rows[i].we)
                ahb(1'b1, rows[i].a, rows[i].d, rd);
            ahb(1'b0, rows[i].a, 32'h0, rd);
            chk_word(rd, rows[i].e, "register readback");
            chk_bit(hresp, 1'b0, "bus response not okay");
        end
        pins.ignition_enable <= 1'b1;
        wait_val(0, 1'b1, 740, 770, n);
        chk_bit(ldo_on, 1'b0, "ldo ahead of prereg");
        pins.prereg_undervoltage <= 1'b0;
        wait_val(1, 1'b1, 1, 6, n);
        pins.main_ldo_undervoltage <= 1'b0;
        wait_val(2, 1'b1, POR + 740, POR + 800, n);
        ahb(1'b0, ADDR_STATUS, 32'h0, rd);
        chk_word(rd & 32'h7, {29'h0, ST_RUN}, "state after startup");
        pins.main_ldo_undervoltage <= 1'b1;
        hold_val(2, 1'b1, 300);
        pins.main_ldo_undervoltage <= 1'b0;
        hold_val(2, 1'b1, 10);
        pins.main_ldo_undervoltage <= 1'b1;
        wait_val(2, 1'b0, 740, 770, n);
        pins.main_ldo_undervoltage <= 1'b0;
        wait_val(2, 1'b1, POR + 740, POR + 800, n);
        count_gate(40, cnt);
        chk_bit(cnt >= 16 && cnt <= 24, 1'b1, "gate duty");
        pins.overcurrent <= 1'b1;
        hold_val(3, 1'b0, 800);
        count_gate(40, cnt);
        chk_bit(cnt == 4, 1'b1, "one cut pulse per cycle under current limit");
        pins.error_amp_max <= 1'b1;
        pins.prereg_below_2v4 <= 1'b1;
        wait_val(3, 1'b1, 1, 200, n6);
        pins.overcurrent <= 1'b0;
        hold_val(5, 1'b0, 30);
        wait_val(3, 1'b0, 1, 60, n);
        pins.prereg_below_2v4 <= 1'b0;
        pins.overcurrent <= 1'b1;
        wait_val(3, 1'b1, 1, 700, n);
        chk_bit(n > 3 * n6, 1'b1, "longer count above threshold");
        pins.overcurrent <= 1'b0;
        pins.error_amp_max <= 1'b0;
        wait_val(3, 1'b0, 1, 60, n);
        foreach (fq_bits[i])
        begin
            pins[fq_bits[i]] <= 1'b1;
            wait_val(4, 1'b1, 140, 160, n);
            chk_bit(por_n, 1'b1, "reset output during frequency fault");
            pins[fq_bits[i]] <= 1'b0;
            wait_val(4, 1'b0, 1, 160, n);
        end
        svc_en <= 1'b1;
        ahb(1'b1, ADDR_CTRL, 32'h00000201, rd);
        hold_val(2, 1'b1, 300);
        svc_en <= 1'b0;
        wait_val(2, 1'b0, 1, 45, n);
        wait_val(2, 1'b1, 18, 24, n);
        ahb(1'b1, ADDR_CTRL, 32'h00000203, rd);
        wait_val(2, 1'b0, 70, 90, n);
        wait_val(2, 1'b1, 18, 24, n);
        ahb(1'b1, ADDR_CTRL, 32'h0, rd);
        foreach (mr_bits[i])
        begin
            pins[mr_bits[i]] <= 1'b1;
            wait_val(0, 1'b0, 1, 5, n);
            chk_bit(ldo_on, 1'b0, "ldo during master reset");
            pins[mr_bits[i]] <= 1'b0;
            wait_val(1, 1'b1, 1, 12, n);
            wait_val(2, 1'b1, 1, POR + 20, n);
        end
        foreach (lat_bits[i])
        begin
            pins[lat_bits[i]] <= 1'b1;
            wait_val(0, 1'b0, 1, 5, n);
            pins[lat_bits[i]] <= 1'b0;
            hold_val(0, 1'b0, 100);
            chk_bit(por_n, 1'b0, "reset output held by latch");
            ahb(1'b0, ADDR_STATUS, 32'h0, rd);
            chk_word(rd & 32'h70, 32'h10 << i, "latched cause");
            pins.ignition_enable <= 1'b0;
            repeat (800) @(posedge ref_clk_in);
            pins.ignition_enable <= 1'b1;
            wait_val(0, 1'b1, 740, 770, n);
            wait_val(2, 1'b1, POR - 10, POR + 20, n);
        end
        pins.ignition_enable <= 1'b0;
        wait_val(2, 1'b0, 740, 900, n);
        wait_val(1, 1'b0, 2400, 2560, n);
        chk_bit(prereg_on, 1'b1, "prereg kept until ldo undervoltage");
        pins.main_ldo_undervoltage <= 1'b1;
        wait_val(0, 1'b0, 1, 800, n);
        tally_and_finish();
    end
endmodule : pss_sequencer_tb_top
